/* hw/fcps_cfg.svh */
// Purpose: Constants for the command parameter and first status byte block
// Assumes: Included by bare name; definitions only
// Notes: Field positions of the first result status byte, codes, reset values, timing
`ifndef FCPS_CFG_SVH
`define FCPS_CFG_SVH

// First result status byte field positions
`define FCPS_ST0_IC_HI 7
`define FCPS_ST0_IC_LO 6
`define FCPS_ST0_SE 5
`define FCPS_ST0_EC 4
`define FCPS_ST0_ZERO 3
`define FCPS_ST0_HEAD 2
`define FCPS_ST0_DS_HI 1
`define FCPS_ST0_DS_LO 0

// Termination codes
`define FCPS_IC_NORMAL 2'h0
`define FCPS_IC_ABNORMAL 2'h1
`define FCPS_IC_INVALID 2'h2
`define FCPS_IC_POLL 2'h3

// Step counts and step interval span
`define FCPS_RECAL_STEPS 8'h50
`define FCPS_SRT_SPAN 5'h10

// Timing: clock period and step interval unit of 0.5 ms
`define FCPS_CLK_PERIOD_NS 4
`define FCPS_STEP_UNIT_US 500
`define FCPS_STEP_UNIT_CYC (`FCPS_STEP_UNIT_US * 1000 / `FCPS_CLK_PERIOD_NS)

// Reset values of the configuration
`define FCPS_RST_PRECOMP_START_TRACK 8'h00
`define FCPS_RST_SRT 4'h0
`define FCPS_RST_RATE 2'h0
`define FCPS_RST_PRECOMP 3'h0

`endif

/* hw/fcps_pkg.sv */
// Purpose: Types for the command parameter and first status byte block
// Assumes: Constants live in fcps_cfg.svh
// Notes: Operations, one-hot states and parameter carriers
package fcps_pkg;

  typedef enum logic [3:0] {
    FCPS_OP_SEEK = 4'h0,
    FCPS_OP_RECAL = 4'h1,
    FCPS_OP_REL_SEEK = 4'h2,
    FCPS_OP_READ = 4'h3,
    FCPS_OP_READ_DEL = 4'h4,
    FCPS_OP_WRITE = 4'h5,
    FCPS_OP_FORMAT = 4'h6,
    FCPS_OP_VERIFY = 4'h7,
    FCPS_OP_SENSE = 4'h8,
    FCPS_OP_INVALID = 4'hF
  } fcps_op_t;

  typedef enum logic [3:0] {
    FCPS_ST_IDLE = 4'h1,
    FCPS_ST_STEP = 4'h2,
    FCPS_ST_XFER = 4'h4,
    FCPS_ST_RES = 4'h8
  } fcps_state_t;

  typedef struct packed {
    logic [3:0] precomp_bypass_select;
    logic polling_disable;
    logic oscillator_off;
    logic [7:0] precomp_start_track;
    logic [3:0] step_interval;
    logic write_window_timing;
    logic [2:0] precomp_delay_value;
    logic [1:0] data_rate;
  } fcps_cfg_t;

  typedef struct packed {
    fcps_op_t op;
    logic [1:0] drive_slot_bits;
    logic head;
    logic [7:0] cylinder;
    logic [7:0] relative_track_offset;
    logic dir_in;
    logic [7:0] sector_addr;
    logic [7:0] sector_total;
    logic deleted_mark_bypass;
    logic enable_count;
    logic implied_seek;
  } fcps_cmd_t;

endpackage

/* hw/fcps_stepper.sv */
// Purpose: Step pulse generator with fixed spacing between pulses
// Assumes: Interval is latched at start; halt is synchronous to clk
// Notes: First pulse two cycles after start, then one pulse per interval
`timescale 1ns/10ps
module fcps_stepper (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [23:0] interval,
  input wire logic halt,
  output logic step_q,
  output logic done_q,
  output logic busy_q,
  output logic [7:0] left_q
);

  logic [23:0] iv_q;
  logic [23:0] tmr_q;
  logic [23:0] gap_q;
  logic seen_q;

  // Pulse train: halt ends early, timer spaces the pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      step_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      left_q <= 8'h00;
      iv_q <= 24'h000000;
      tmr_q <= 24'h000000;
    end else if (ce) begin
      step_q <= 1'b0;
      done_q <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        left_q <= count;
        tmr_q <= 24'h000000;
        iv_q <= interval;
      end else if (busy_q) begin
        if (halt) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else if (tmr_q == 24'h000000) begin
          if (left_q == 8'h00) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            step_q <= 1'b1;
            left_q <= left_q - 8'h01;
            tmr_q <= iv_q - 24'h000001;
          end
        end else begin
          tmr_q <= tmr_q - 24'h000001;
        end
      end
    end
  end

  // Cycles since the last pulse, for the spacing check
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_q <= 24'h000000;
      seen_q <= 1'b0;
    end else if (ce) begin
      gap_q <= step_q ? 24'h000000 : gap_q + 24'h000001;
      seen_q <= start ? 1'b0 : (seen_q | step_q);
    end
  end

  step_spacing_a: assert property (@(posedge clk) disable iff (rst)
    ce && step_q && seen_q |-> gap_q == iv_q - 24'h000001)
    else $error("step pulses not spaced by the step interval");

  step_after_start_a: assert property (@(posedge clk) disable iff (rst)
    ce && start && count != 8'h00 && !halt ##1 ce && !halt |=> step_q)
    else $error("first step pulse missing after start");

endmodule

/* hw/fcps_top.sv */
// Purpose: Command parameter interpreter and first result status byte builder
// Assumes: All inputs synchronous to clk; host takes results with res_rd
// Notes: Seeks report through the sense command; transfers report directly
//
// Summary of operation
// - Drive with bypass bit set gets no precompensation; else programmed delay.
// - Polling disable set suspends drive polling; clear keeps it running.
// - Oscillator-off parameter set stops the internal oscillator.
// - Precompensation starts at the programmed start track, 00 to FFh.
// - Step interval spaces step pulses, 0.5 ms to 8 ms at 1 Mbit.
// - Read data with bypass flag skips sectors with deleted marks.
// - Read deleted with bypass takes only deleted sectors; flag clear reads all.
// - Sector address names the first sector; later sectors follow it.
// - Sector total bounds format, and verify when enable-count is set.
// - Relative seek moves by the offset from the present cylinder.
// - Sense command returns the head's current cylinder position.
// - Write window timing moves write strobe earlier for pre-erase.
// - Status is captured per command and read only as result bytes.
// - Bits 7 and 6 give one of four termination outcomes.
// - Bit 5 set when seek, recalibrate or implied seek completes.
// - Bit 4 set on recalibrate without track zero or outward overrun.
// - Bit 3 always reads zero.
// - Bit 2 reports the current head address.
// - Bits 1 and 0 report the selected drive.
`timescale 1ns/10ps
`include "fcps_cfg.svh"
module fcps_top #(
  parameter int STEP_UNIT_CYC = `FCPS_STEP_UNIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire fcps_pkg::fcps_cfg_t cfg_i,
  input wire logic cmd_go,
  input wire fcps_pkg::fcps_cmd_t cmd_i,
  input wire logic res_rd,
  input wire logic track0,
  input wire logic sec_seen,
  input wire logic sec_deleted,
  input wire logic term_count,
  input wire logic ready_change,
  input wire logic [1:0] ready_drive,
  output logic step_pulse,
  output logic step_dir_q,
  output logic [2:0] precomp_q,
  output logic poll_active_q,
  output logic osc_run_q,
  output logic wr_strobe_q,
  output logic sector_take_q,
  output logic [7:0] cur_sector_q,
  output logic res_valid_q,
  output logic [7:0] result_status_zero_q,
  output logic [7:0] present_cylinder_value_q,
  output logic busy_q
);

  // Assemble the first result status byte
  function automatic logic [7:0] fcps_st0(input logic [1:0] ic, input logic se,
                                          input logic ec, input logic hd,
                                          input logic [1:0] ds);
    logic [7:0] r;
    r = 8'h00;
    r[`FCPS_ST0_IC_HI:`FCPS_ST0_IC_LO] = ic;
    r[`FCPS_ST0_SE] = se;
    r[`FCPS_ST0_EC] = ec;
    r[`FCPS_ST0_ZERO] = 1'b0;
    r[`FCPS_ST0_HEAD] = hd;
    r[`FCPS_ST0_DS_HI:`FCPS_ST0_DS_LO] = ds;
    fcps_st0 = r;
  endfunction

  // Operations that move data after any positioning
  function automatic logic fcps_is_xfer(input fcps_pkg::fcps_op_t op);
    fcps_is_xfer = (op == fcps_pkg::FCPS_OP_READ) || (op == fcps_pkg::FCPS_OP_READ_DEL) ||
                   (op == fcps_pkg::FCPS_OP_WRITE);
  endfunction

  // Step interval scale per data rate code
  function automatic logic [2:0] fcps_rate_mul(input logic [1:0] rate);
    case (rate)
      2'h3: fcps_rate_mul = 3'h1;
      2'h0: fcps_rate_mul = 3'h2;
      2'h1: fcps_rate_mul = 3'h3;
      default: fcps_rate_mul = 3'h4;
    endcase
  endfunction

  fcps_pkg::fcps_cfg_t cfg_q;
  fcps_pkg::fcps_cmd_t cmd_q;
  fcps_pkg::fcps_state_t state_q;
  fcps_pkg::fcps_state_t state_d;
  logic [7:0] pcn_q [4];
  logic pend_q;
  logic [7:0] pend_st0_q;
  logic se_q;
  logic [7:0] cnt_q;
  logic step_start_q;
  logic [7:0] step_cnt_q;
  logic step_done;
  logic [7:0] step_left;

  // Command decode and positioning arithmetic
  wire go_w = cmd_go && (state_q == fcps_pkg::FCPS_ST_IDLE);
  wire fcps_pkg::fcps_op_t op_i_w = cmd_i.op;
  wire fcps_pkg::fcps_op_t op_q_w = cmd_q.op;
  wire [1:0] drv_w = cmd_q.drive_slot_bits;
  wire [7:0] pcn_cur_w = pcn_q[drv_w];
  wire [7:0] pcn_in_w = pcn_q[cmd_i.drive_slot_bits];
  wire abs_in_w = cmd_i.cylinder > pcn_in_w;
  wire [7:0] abs_cnt_w = abs_in_w ? cmd_i.cylinder - pcn_in_w : pcn_in_w - cmd_i.cylinder;
  wire is_recal_w = op_i_w == fcps_pkg::FCPS_OP_RECAL;
  wire is_rel_w = op_i_w == fcps_pkg::FCPS_OP_REL_SEEK;
  wire [7:0] seek_cnt_w = is_recal_w ? `FCPS_RECAL_STEPS :
                          is_rel_w ? cmd_i.relative_track_offset : abs_cnt_w;
  wire seek_dir_w = is_recal_w ? 1'b0 : is_rel_w ? cmd_i.dir_in : abs_in_w;
  wire seek_op_w = is_recal_w || is_rel_w || (op_i_w == fcps_pkg::FCPS_OP_SEEK);
  wire go_step_w = go_w && (seek_op_w || (fcps_is_xfer(op_i_w) && cmd_i.implied_seek));

  // Stepper control; halting on track zero only when moving outward
  wire q_recal_w = op_q_w == fcps_pkg::FCPS_OP_RECAL;
  wire q_rel_w = op_q_w == fcps_pkg::FCPS_OP_REL_SEEK;
  wire halt_w = track0 && !step_dir_q && (q_recal_w || q_rel_w);
  wire seek_end_w = (state_q == fcps_pkg::FCPS_ST_STEP) && step_done;
  wire seek_ec_w = (q_recal_w && !track0) || (q_rel_w && step_left != 8'h00);
  wire [4:0] srt_span_w = `FCPS_SRT_SPAN - {1'b0, cfg_q.step_interval};
  wire [23:0] step_iv_w = 24'(STEP_UNIT_CYC) * 24'(srt_span_w) *
                          24'(fcps_rate_mul(cfg_q.data_rate));

  // Sector handling during transfers
  wire xfer_w = state_q == fcps_pkg::FCPS_ST_XFER;
  wire skip_w = cmd_q.deleted_mark_bypass &&
                (((op_q_w == fcps_pkg::FCPS_OP_READ) && sec_deleted) ||
                 ((op_q_w == fcps_pkg::FCPS_OP_READ_DEL) && !sec_deleted));
  wire take_w = xfer_w && sec_seen && !skip_w;
  wire count_lim_w = (op_q_w == fcps_pkg::FCPS_OP_FORMAT) ||
                     ((op_q_w == fcps_pkg::FCPS_OP_VERIFY) && cmd_q.enable_count);
  wire count_end_w = take_w && count_lim_w && (cnt_q + 8'h01 == cmd_q.sector_total);
  wire xfer_end_w = xfer_w && (term_count || count_end_w);
  wire xfer_entry_w = (state_d == fcps_pkg::FCPS_ST_XFER) && !xfer_w;
  wire fcps_pkg::fcps_cmd_t cmd_src_w = (state_q == fcps_pkg::FCPS_ST_IDLE) ? cmd_i : cmd_q;

  // Result and pending status sources
  wire sense_w = go_w && (op_i_w == fcps_pkg::FCPS_OP_SENSE);
  wire sense_hit_w = sense_w && pend_q;
  wire [7:0] go_st0_w = sense_hit_w ? pend_st0_q :
                        fcps_st0(`FCPS_IC_INVALID, 1'b0, 1'b0, 1'b0, 2'h0);
  wire [7:0] xfer_st0_w = fcps_st0(`FCPS_IC_NORMAL, se_q, 1'b0, cmd_q.head, drv_w);
  wire [7:0] seek_st0_w = fcps_st0(seek_ec_w ? `FCPS_IC_ABNORMAL : `FCPS_IC_NORMAL,
                                   1'b1, seek_ec_w, cmd_q.head, drv_w);
  wire poll_evt_w = (state_q == fcps_pkg::FCPS_ST_IDLE) && poll_active_q && ready_change;

  fcps_stepper u_step (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(step_start_q),
    .count(step_cnt_q),
    .interval(step_iv_w),
    .halt(halt_w),
    .step_q(step_pulse),
    .done_q(step_done),
    .busy_q(),
    .left_q(step_left)
  );

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcps_pkg::FCPS_ST_IDLE: begin
        if (go_w) begin
          if (go_step_w) begin
            state_d = fcps_pkg::FCPS_ST_STEP;
          end else if (fcps_is_xfer(op_i_w) || op_i_w == fcps_pkg::FCPS_OP_FORMAT ||
                       op_i_w == fcps_pkg::FCPS_OP_VERIFY) begin
            state_d = fcps_pkg::FCPS_ST_XFER;
          end else begin
            state_d = fcps_pkg::FCPS_ST_RES;
          end
        end
      end
      fcps_pkg::FCPS_ST_STEP: begin
        if (step_done) begin
          state_d = fcps_is_xfer(op_q_w) ? fcps_pkg::FCPS_ST_XFER : fcps_pkg::FCPS_ST_IDLE;
        end
      end
      fcps_pkg::FCPS_ST_XFER: begin
        if (xfer_end_w) begin
          state_d = fcps_pkg::FCPS_ST_RES;
        end
      end
      fcps_pkg::FCPS_ST_RES: begin
        if (res_rd) begin
          state_d = fcps_pkg::FCPS_ST_IDLE;
        end
      end
      default: state_d = fcps_pkg::FCPS_ST_IDLE;
    endcase
  end

  // State, configuration and command capture
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= fcps_pkg::FCPS_ST_IDLE;
      cfg_q <= {4'h0, 1'b0, 1'b0, `FCPS_RST_PRECOMP_START_TRACK, `FCPS_RST_SRT, 1'b0,
                `FCPS_RST_PRECOMP, `FCPS_RST_RATE};
      cmd_q <= '0;
      busy_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      busy_q <= state_d != fcps_pkg::FCPS_ST_IDLE;
      if (cfg_wr) begin
        cfg_q <= cfg_i;
      end
      if (go_w) begin
        cmd_q <= cmd_i;
      end
    end
  end

  // Positioning: start the stepper and track each head
  always_ff @(posedge clk) begin
    if (rst) begin
      step_start_q <= 1'b0;
      step_cnt_q <= 8'h00;
      step_dir_q <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pcn_q[i] <= 8'h00;
      end
    end else if (ce) begin
      step_start_q <= go_step_w;
      if (go_step_w) begin
        step_cnt_q <= seek_cnt_w;
        step_dir_q <= seek_dir_w;
      end
      if (step_pulse) begin
        pcn_q[drv_w] <= step_dir_q ? pcn_cur_w + 8'h01 : pcn_cur_w - 8'h01;
      end else if (seek_end_w && halt_w) begin
        pcn_q[drv_w] <= 8'h00;
      end
    end
  end

  // Pending seek or polling status, the set wins over the sense clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_st0_q <= 8'h00;
    end else if (ce) begin
      if (sense_w) begin
        pend_q <= 1'b0;
      end
      if (seek_end_w && !fcps_is_xfer(op_q_w)) begin
        pend_q <= 1'b1;
        pend_st0_q <= seek_st0_w;
      end
      if (poll_evt_w) begin
        pend_q <= 1'b1;
        pend_st0_q <= fcps_st0(`FCPS_IC_POLL, 1'b0, 1'b0, 1'b0, ready_drive);
      end
    end
  end

  // Sector sequencing and write strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_sector_q <= 8'h00;
      cnt_q <= 8'h00;
      se_q <= 1'b0;
      sector_take_q <= 1'b0;
      wr_strobe_q <= 1'b0;
    end else if (ce) begin
      sector_take_q <= take_w;
      if (xfer_entry_w) begin
        cur_sector_q <= cmd_src_w.sector_addr;
        cnt_q <= 8'h00;
        se_q <= state_q == fcps_pkg::FCPS_ST_STEP;
        wr_strobe_q <= cfg_q.write_window_timing &&
                       (cmd_src_w.op == fcps_pkg::FCPS_OP_WRITE);
      end else if (xfer_w && state_d != fcps_pkg::FCPS_ST_XFER) begin
        wr_strobe_q <= 1'b0;
      end else if (xfer_w && sec_seen) begin
        cur_sector_q <= cur_sector_q + 8'h01;
        if (take_w) begin
          cnt_q <= cnt_q + 8'h01;
          wr_strobe_q <= wr_strobe_q || (op_q_w == fcps_pkg::FCPS_OP_WRITE);
        end
      end
    end
  end

  // Result phase bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      result_status_zero_q <= 8'h00;
      present_cylinder_value_q <= 8'h00;
    end else if (ce) begin
      res_valid_q <= state_d == fcps_pkg::FCPS_ST_RES;
      if (go_w && !go_step_w && state_d == fcps_pkg::FCPS_ST_RES) begin
        result_status_zero_q <= go_st0_w;
        present_cylinder_value_q <= sense_hit_w ? pcn_q[pend_st0_q[1:0]] : pcn_in_w;
      end else if (xfer_end_w) begin
        result_status_zero_q <= xfer_st0_w;
        present_cylinder_value_q <= pcn_cur_w;
      end
    end
  end

  // Precompensation, polling and oscillator controls
  always_ff @(posedge clk) begin
    if (rst) begin
      precomp_q <= 3'h0;
      poll_active_q <= 1'b1;
      osc_run_q <= 1'b1;
    end else if (ce) begin
      precomp_q <= (cfg_q.precomp_bypass_select[drv_w] ||
                    pcn_cur_w < cfg_q.precomp_start_track) ? 3'h0 :
                   cfg_q.precomp_delay_value;
      poll_active_q <= !cfg_q.polling_disable;
      osc_run_q <= !cfg_q.oscillator_off;
    end
  end

  bit3_zero_a: assert property (@(posedge clk) disable iff (rst)
    result_status_zero_q[`FCPS_ST0_ZERO] == 1'b0)
    else $error("status bit 3 not zero");

  precomp_bypass_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_q.precomp_bypass_select[drv_w] |=> precomp_q == 3'h0)
    else $error("precompensation applied to bypassed drive");

  precomp_track_a: assert property (@(posedge clk) disable iff (rst)
    ce && !cfg_q.precomp_bypass_select[drv_w] && pcn_cur_w >= cfg_q.precomp_start_track
    |=> precomp_q == $past(cfg_q.precomp_delay_value))
    else $error("precompensation missing at or after start track");

  poll_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && cfg_i.polling_disable ##1 ce |=> !poll_active_q)
    else $error("polling not suspended");

  osc_stop_a: assert property (@(posedge clk) disable iff (rst)
    ce && cfg_wr && cfg_i.oscillator_off ##1 ce |=> !osc_run_q)
    else $error("oscillator not stopped");

  skip_deleted_a: assert property (@(posedge clk) disable iff (rst)
    ce && xfer_w && sec_seen && sec_deleted && cmd_q.deleted_mark_bypass &&
    op_q_w == fcps_pkg::FCPS_OP_READ |=> !sector_take_q)
    else $error("deleted sector taken while skipping");

  only_deleted_a: assert property (@(posedge clk) disable iff (rst)
    ce && xfer_w && sec_seen && (sec_deleted || !cmd_q.deleted_mark_bypass) &&
    op_q_w == fcps_pkg::FCPS_OP_READ_DEL |=> sector_take_q)
    else $error("qualifying sector not taken");

  seek_end_a: assert property (@(posedge clk) disable iff (rst)
    ce && seek_end_w && !fcps_is_xfer(op_q_w) |=> pend_q && pend_st0_q[`FCPS_ST0_SE])
    else $error("seek end not reported");

  recal_fail_a: assert property (@(posedge clk) disable iff (rst)
    ce && seek_end_w && q_recal_w && !track0 |=>
    pend_st0_q[`FCPS_ST0_EC] && pend_st0_q[7:6] == `FCPS_IC_ABNORMAL)
    else $error("recalibrate failure not flagged");

  invalid_code_a: assert property (@(posedge clk) disable iff (rst)
    ce && go_w && op_i_w == fcps_pkg::FCPS_OP_INVALID |=>
    res_valid_q && result_status_zero_q[7:6] == `FCPS_IC_INVALID)
    else $error("invalid command code wrong");

  sense_cyl_a: assert property (@(posedge clk) disable iff (rst)
    ce && sense_hit_w |=> present_cylinder_value_q == $past(pcn_q[pend_st0_q[1:0]]))
    else $error("sense cylinder differs from head position");

  drive_head_a: assert property (@(posedge clk) disable iff (rst)
    ce && xfer_end_w |=> result_status_zero_q[2:0] == {$past(cmd_q.head), $past(drv_w)})
    else $error("head or drive field wrong");

endmodule

/* sim/fcps_drive_model.sv */
// Purpose: Drive model that follows step pulses and reports track zero
// Assumes: One head move per step pulse; inward counts up
// Notes: stuck hides the track zero sensor to model a broken drive
`timescale 1ns/10ps
module fcps_drive_model (
  input wire logic clk,
  input wire logic stuck,
  input wire logic step_pulse,
  input wire logic step_dir_q,
  output logic track0,
  output logic [7:0] cyl_q
);
  // Head position; outward travel stops at the outer end
  always @(posedge clk) begin
    if (step_pulse === 1'b1 && step_dir_q === 1'b1) begin
      cyl_q <= cyl_q + 8'h01;
    end else if (step_pulse === 1'b1 && cyl_q != 8'h00) begin
      cyl_q <= cyl_q - 8'h01;
    end
  end
  initial cyl_q = 8'h00;
  // Sensor high only at the outer end unless broken
  assign track0 = (cyl_q == 8'h00) && !stuck;
endmodule

/* sim/fcps_cmd_param_status_bench.sv */
// Purpose: Self-checking bench for the command parameter and status block
// Assumes: Short step unit; drive model answers the stepper
// Notes: Tests are command sequences read back through result bytes
`timescale 1ns/10ps
module fcps_cmd_param_status_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfg_wr = 1'b0;
  logic cmd_go = 1'b0;
  logic res_rd = 1'b0;
  logic sec_seen = 1'b0;
  logic sec_deleted = 1'b0;
  logic term_count = 1'b0;
  logic ready_change = 1'b0;
  logic [1:0] ready_drive = 2'h0;
  logic stuck = 1'b0;
  fcps_pkg::fcps_cfg_t cfg_i = '0;
  fcps_pkg::fcps_cmd_t cmd_i = '0;
  logic track0, step_pulse, step_dir_q, poll_active_q, osc_run_q, res_valid_q, busy_q;
  logic [7:0] cyl_q, cur_sector_q, st0, present_cylinder_value;
  logic took, sector_take_q, wr_strobe;
  logic [2:0] precomp;
  fcps_pkg::fcps_op_t rd_op;
  int n_mismatch = 0;
  int checks = 0;
  int steps = 0;
  int base = 0;

  always #2 clk = ~clk;
  // Count step pulses seen by the drive
  always @(posedge clk) if (step_pulse === 1'b1) steps <= steps + 1;

  fcps_top #(.STEP_UNIT_CYC(4)) dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .cfg_wr(cfg_wr), .cfg_i(cfg_i), .cmd_go(cmd_go),
    .cmd_i(cmd_i), .res_rd(res_rd), .track0(track0), .sec_seen(sec_seen),
    .sec_deleted(sec_deleted), .term_count(term_count), .ready_change(ready_change),
    .ready_drive(ready_drive), .step_pulse(step_pulse), .step_dir_q(step_dir_q),
    .precomp_q(precomp), .poll_active_q(poll_active_q), .osc_run_q(osc_run_q),
    .wr_strobe_q(wr_strobe), .sector_take_q(sector_take_q), .cur_sector_q(cur_sector_q),
    .res_valid_q(res_valid_q),
    .result_status_zero_q(st0), .present_cylinder_value_q(present_cylinder_value), .busy_q(busy_q));

  fcps_drive_model drv_u (.clk(clk), .stuck(stuck), .step_pulse(step_pulse),
    .step_dir_q(step_dir_q), .track0(track0), .cyl_q(cyl_q));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Bounded wait for result valid or for idle
  task automatic wait_for(input bit on_res, input int lim);
    int i;
    #1;
    for (i = 0; i < lim; i++) begin
      if (on_res ? res_valid_q === 1'b1 : busy_q === 1'b0) break;
      @(posedge clk);
      #1;
    end
    if (i == lim) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // One command; v serves as cylinder, offset, sector and count
  task automatic issue(input fcps_pkg::fcps_op_t op, input logic [2:0] dh,
      input logic [7:0] v, input logic dir, input logic sk);
    @(posedge clk);
    cmd_i <= '{op: op, drive_slot_bits: dh[1:0], head: dh[2], cylinder: v,
      relative_track_offset: v, dir_in: dir, sector_addr: v, sector_total: v,
      deleted_mark_bypass: sk, enable_count: 1'b0, implied_seek: 1'b0};
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
  endtask

  // Read result bytes, then release them
  task automatic result(input logic [7:0] mask, input logic [7:0] exp,
      input logic [7:0] cyl, input bit chkc);
    wait_for(1'b1, 100);
    chk(st0 & mask, exp);
    if (chkc) chk(present_cylinder_value, cyl);
    @(posedge clk);
    res_rd <= 1'b1;
    @(posedge clk);
    res_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk({7'h00, res_valid_q}, 8'h00);
  endtask

  task automatic sense(input logic [7:0] mask, input logic [7:0] exp,
      input logic [7:0] cyl, input bit chkc);
    issue(fcps_pkg::FCPS_OP_SENSE, 3'h0, 8'h00, 1'b0, 1'b0);
    result(mask, exp, cyl, chkc);
  endtask

  task automatic move(input fcps_pkg::fcps_op_t op, input logic [7:0] v, input logic dir);
    issue(op, 3'h5, v, dir, 1'b0);
    wait_for(1'b0, 30000);
  endtask

  task automatic sector(input logic del);
    @(posedge clk);
    sec_seen <= 1'b1;
    sec_deleted <= del;
    @(posedge clk);
    sec_seen <= 1'b0;
    sec_deleted <= 1'b0;
    #1;
    // Accept pulse stands for the one cycle after the sector
    took = sector_take_q;
    @(posedge clk);
    #1;
  endtask

  // Pulse a polling event or a configuration load
  task automatic pulse(input bit is_cfg);
    @(posedge clk);
    if (is_cfg) cfg_wr <= 1'b1;
    else ready_change <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    ready_change <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({6'h00, poll_active_q, osc_run_q}, 8'h03);
    chk({busy_q, res_valid_q, 6'h00}, 8'h00);
    ready_drive <= 2'h2;
    pulse(1'b0);
    sense(8'hFB, 8'hC2, 8'h00, 1'b0);
    sense(8'hFF, 8'h80, 8'h00, 1'b0);
    $display("test polling done");
    cfg_i.step_interval <= 4'hF;
    cfg_i.data_rate <= 2'h3;
    pulse(1'b1);
    base = steps;
    move(fcps_pkg::FCPS_OP_SEEK, 8'h05, 1'b1);
    chk(8'(steps - base), 8'h05);
    chk(cyl_q, 8'h05);
    sense(8'hFF, 8'h25, 8'h05, 1'b1);
    move(fcps_pkg::FCPS_OP_REL_SEEK, 8'h03, 1'b1);
    sense(8'hFF, 8'h25, 8'h08, 1'b1);
    move(fcps_pkg::FCPS_OP_REL_SEEK, 8'h0C, 1'b0);
    sense(8'hFF, 8'h75, 8'h00, 1'b1);
    stuck <= 1'b1;
    base = steps;
    move(fcps_pkg::FCPS_OP_RECAL, 8'h00, 1'b0);
    chk(8'(steps - base), 8'h50);
    sense(8'hFF, 8'h75, 8'h00, 1'b0);
    stuck <= 1'b0;
    $display("test positioning done");
    issue(fcps_pkg::FCPS_OP_INVALID, 3'h0, 8'h00, 1'b0, 1'b0);
    result(8'hC8, 8'h80, 8'h00, 1'b0);
    // Reads: bypass, deleted with bypass, plain; writes: late strobe, then early strobe
    for (int k = 0; k < 5; k++) begin
      rd_op = fcps_pkg::FCPS_OP_READ;
      if (k == 1) rd_op = fcps_pkg::FCPS_OP_READ_DEL;
      if (k > 2) rd_op = fcps_pkg::FCPS_OP_WRITE;
      if (k == 4) begin
        cfg_i.write_window_timing <= 1'b1;
        pulse(1'b1);
      end
      issue(rd_op, 3'h6, 8'h0A, 1'b0, k != 2);
      #1;
      chk(cur_sector_q, 8'h0A);
      chk({7'h00, wr_strobe}, k == 4 ? 8'h01 : 8'h00);
      sector(1'b0);
      chk(cur_sector_q, 8'h0B);
      chk({7'h00, took}, k == 1 ? 8'h00 : 8'h01);
      chk({7'h00, wr_strobe}, k > 2 ? 8'h01 : 8'h00);
      sector(1'b1);
      chk(cur_sector_q, 8'h0C);
      chk({7'h00, took}, k == 0 ? 8'h00 : 8'h01);
      @(posedge clk);
      term_count <= 1'b1;
      @(posedge clk);
      term_count <= 1'b0;
      result(8'hFF, 8'h06, 8'h00, 1'b0);
    end
    issue(fcps_pkg::FCPS_OP_FORMAT, 3'h3, 8'h02, 1'b0, 1'b0);
    sector(1'b0);
    chk({7'h00, res_valid_q}, 8'h00);
    sector(1'b0);
    result(8'hFF, 8'h03, 8'h00, 1'b0);
    $display("test transfers done");
    cfg_i.polling_disable <= 1'b1;
    cfg_i.oscillator_off <= 1'b1;
    cfg_i.precomp_delay_value <= 3'h5;
    pulse(1'b1);
    chk({6'h00, poll_active_q, osc_run_q}, 8'h00);
    chk({5'h00, precomp}, 8'h05);
    cfg_i.precomp_bypass_select <= 4'h8;
    pulse(1'b1);
    chk({5'h00, precomp}, 8'h00);
    cfg_i.precomp_bypass_select <= 4'h7;
    cfg_i.precomp_start_track <= 8'h01;
    pulse(1'b1);
    chk({5'h00, precomp}, 8'h00);
    pulse(1'b0);
    sense(8'hFF, 8'h80, 8'h00, 1'b0);
    $display("test config done");
    tally_and_finish;
  end
endmodule
